// ---- shared/mie_defines.svh ----
// Purpose: offsets, field positions, reset values for the move executor
// Assumes: byte addresses on a 32-bit apb, one aligned word per register
// Notes:   instruction word layout is shared with software tooling
`ifndef MIE_DEFINES_SVH
`define MIE_DEFINES_SVH

// register byte offsets
`define MIE_OFF_INSTR     12'h000
`define MIE_OFF_WORK      12'h004
`define MIE_OFF_STATUS    12'h008
`define MIE_OFF_BANK      12'h00c
`define MIE_OFF_PCLATCH   12'h010
`define MIE_OFF_PTR0      12'h014
`define MIE_OFF_PTR1      12'h018
`define MIE_OFF_MEM_ADDR  12'h01c
`define MIE_OFF_MEM_DATA  12'h020

// instruction word fields
`define MIE_OP_MSB        15
`define MIE_OP_LSB        12
`define MIE_SEL_BIT       8
`define MIE_MODE_MSB      1
`define MIE_MODE_LSB      0
`define MIE_OFS_MSB       5
`define MIE_LIT_MSB       7
`define MIE_BANK_MSB      4
`define MIE_PCL_MSB       6
`define MIE_FILE_MSB      6

// status bits
`define MIE_ST_ZERO       0
`define MIE_ST_CARRY      1
`define MIE_ST_BADOP      2

// reset values
`define MIE_RST_INSTR     16'h0000
`define MIE_RST_WORK      8'h00
`define MIE_RST_BANK      5'h00
`define MIE_RST_PCLATCH   7'h00
`define MIE_RST_PTR       16'h0000
`define MIE_RST_DATA      32'h0000_0000

`endif

// ---- shared/mie_pkg.sv ----
// Purpose: types for the move instruction executor
// Assumes: included with mie_defines.svh for the numeric constants
// Notes:   opcode values are the top nibble of the instruction word
package mie_pkg;

  // one-hot execution states
  typedef enum logic [1:0] {
    MIE_ST_IDLE = 2'b01,
    MIE_ST_EXEC = 2'b10
  } mie_state_t;

  // opcode nibble
  typedef enum logic [3:0] {
    MIE_OP_NONE           = 4'h0,
    MIE_OP_INDIRECT_LOAD  = 4'h1,
    MIE_OP_INDIRECT_STORE = 4'h2,
    MIE_OP_BANK_LITERAL   = 4'h3,
    MIE_OP_PC_LATCH_LIT   = 4'h4,
    MIE_OP_WORK_LITERAL   = 4'h5,
    MIE_OP_WORK_TO_FILE   = 4'h6,
    MIE_OP_LOAD_RELATIVE  = 4'h7,
    MIE_OP_STORE_RELATIVE = 4'h8
  } mie_op_t;

  // pointer_mode_field encodings
  typedef enum logic [1:0] {
    MIE_MODE_PRE_INC  = 2'b00,
    MIE_MODE_PRE_DEC  = 2'b01,
    MIE_MODE_POST_INC = 2'b10,
    MIE_MODE_POST_DEC = 2'b11
  } mie_mode_t;

  // write port toward the data store
  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } mie_mem_wr_t;

  // whole state of the executor
  typedef struct packed {
    mie_state_t        state;
    logic [15:0]       instr;
    logic [7:0]        work;
    logic              zero;
    logic              carry;
    logic              bad_op;
    logic [4:0]        bank_select_reg;
    logic [6:0]        pc_high_latch;
    logic [1:0][15:0]  indirect_pointer;
    logic [15:0]       mem_addr;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } mie_regs_t;

endpackage : mie_pkg

// ---- verilog/mie_data_mem.sv ----
// Purpose: byte-wide data store reached by the move executor
// Assumes: one write port, one combinational read port
// Notes:   addresses above the store size fold onto it (low bits only)
`timescale 1ns/1ps

module mie_data_mem
  import mie_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic        pclk,
  input  wire mie_mem_wr_t wr,
  input  wire logic [15:0] raddr,
  output logic      [7:0]  rdata
);

  // refuse sizes the 16-bit pointers cannot address
  initial begin
    if (ADDR_W < 1 || ADDR_W > 16) begin
      $error("mie_data_mem: ADDR_W out of range");
    end
  end

  logic [7:0] mem [0:(1<<ADDR_W)-1];

  // synchronous write; no reset, contents are undefined at power up
  always_ff @(posedge pclk) begin
    if (wr.we) begin
      mem[wr.addr[ADDR_W-1:0]] <= wr.data;
    end
  end

  // read is combinational so an access completes in one exec cycle
  assign rdata = mem[raddr[ADDR_W-1:0]];

endmodule : mie_data_mem

// ---- verilog/mie_move_exec.sv ----
// Purpose: executes data-move instructions written over apb
// Assumes: pclk 50 MHz, presetn asynchronous active low
// Notes:   one instruction at a time; exec takes the cycle after the write
`timescale 1ns/1ps
`include "mie_defines.svh"

// Summary of operation
// RULE1: an indirect load copies the addressed byte into work and sets zero, a store writes work there.
// RULE2: the virtual indirect register owns no storage and always aliases the byte the pointer names.
// RULE3: auto-modify forms step the pointer before forming the address or after the transfer.
// RULE4: the pointer mode field decodes 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// RULE5: the relative form addresses pointer plus a signed offset of -32..31 and keeps the pointer.
// RULE6: after an auto-modify transfer the pointer holds its value plus or minus one.
// RULE7: pointers span 0000h..FFFFh and wrap modulo 16 bits.
// RULE8: stepping a pointer leaves every status flag untouched.
// RULE9: the bank literal op loads the bank select register without touching flags.
// RULE10: the pc latch literal op loads the seven-bit pc high latch without touching flags.
// RULE11: the work literal op loads the eight-bit literal into work in one cycle, flags untouched.
// RULE12: the work to file op stores work into file register 0..127 of the bank, flags untouched.
// RULE13: a select bit chooses pointer 0 or pointer 1 and its matching virtual register.
module mie_move_exec
  import mie_pkg::*;
#(
  parameter int MEM_ADDR_W = 8
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // the store must be reachable by the 16-bit pointers
  initial begin
    if (MEM_ADDR_W < 1 || MEM_ADDR_W > 16) begin
      $error("mie_move_exec: MEM_ADDR_W out of range");
    end
  end

  // register map, byte offsets on the apb side:
  //   000 instruction word; writing it starts one execution cycle
  //   004 work register, low eight bits
  //   008 status: bit 0 zero, bit 1 carry, bit 2 sticky bad opcode
  //   00c bank select register, low five bits
  //   010 pc high latch, low seven bits
  //   014 pointer 0, 018 pointer 1, sixteen bits each
  //   01c store address used by the byte window below
  //   020 byte window into the data store at that address
  // every other offset, unaligned ones too, answers with pslverr and
  // a zero read word; a refused write changes nothing
  //
  // instruction word layout:
  //   [15:12] opcode, [8] pointer select, [1:0] pointer mode field
  //   [5:0] signed offset of the relative forms
  //   [7:0] work literal, [4:0] bank literal, [6:0] pc latch literal
  //   [6:0] file address of the work to file op, inside the bank
  // opcodes 0 and 9..15 are not decoded; they raise the sticky flag and
  // change nothing else, so software can tell a bad word from a no-op
  //
  // bus timing: the setup cycle is followed by an access cycle in which
  // the answer is prepared, and pready rises for the next cycle only.
  // while an instruction executes the answer waits one more cycle, so
  // a transfer never sees half of an instruction's results. a write
  // lands at the completing edge; an instruction word executes in the
  // cycle after it and its results are readable from the next one.
  //
  // hazards kept in mind:
  //   the store is read combinationally, so the load result and the
  //   zero flag come from the same byte in the same cycle
  //   the bus byte window and the executing instruction never write the
  //   store in one cycle, because the bus cannot complete during exec
  //   pointer steps use 16-bit sums, so the wrap needs no extra logic
  //   and neither carry nor zero ever sees it
  //   the pointer update and a bus write to that pointer cannot meet
  //   for the same reason; no priority between them is needed
  //
  // limitations:
  //   the store holds 2**MEM_ADDR_W bytes; pointer and file addresses
  //   above that fold onto its low bits
  //   the store has no reset, so a byte reads as unknown until written
  //   carry is only ever changed by a status write
  //   the bank field is five bits wide; values above 15 are kept as
  //   written, the decode does not refuse them
  //   one instruction at a time: there is no queue behind the word

  mie_regs_t   q;
  mie_regs_t   d;
  mie_mem_wr_t mem_wr;
  logic [15:0] mem_raddr;
  logic [7:0]  mem_rdata;

  // decoded instruction fields
  mie_op_t     op;
  mie_mode_t   mode;
  logic        sel;
  logic [15:0] ptr_now;
  logic [15:0] ptr_step;
  logic [15:0] ptr_pre;
  logic [15:0] ptr_post;
  logic [15:0] ofs_ext;
  logic [15:0] eff_addr;
  logic [15:0] file_addr;
  logic        is_pre;

  // bus decode
  logic        setup_seen;
  logic        bus_done;
  logic        mapped;
  logic [31:0] rd_mux;

  mie_data_mem #(
    .ADDR_W (MEM_ADDR_W)
  ) u_mem (
    .pclk  (pclk),
    .wr    (mem_wr),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // instruction field extraction
  assign op   = mie_op_t'(q.instr[`MIE_OP_MSB:`MIE_OP_LSB]);
  assign mode = mie_mode_t'(q.instr[`MIE_MODE_MSB:`MIE_MODE_LSB]);
  assign sel  = q.instr[`MIE_SEL_BIT];                      // [RULE13]
  assign ptr_now = q.indirect_pointer[sel];                 // [RULE13]

  // plus one for increments, all ones (minus one) for decrements
  assign ptr_step = mode[0] ? 16'hffff : 16'h0001;          // [RULE4]
  assign is_pre   = ~mode[1];                               // [RULE4]
  // 16-bit sums drop the carry, which is the wrap
  assign ptr_pre  = 16'(ptr_now + ptr_step);                // [RULE7]
  assign ptr_post = ptr_pre;                                // [RULE6]

  // sign-extend the six-bit offset, range -32..31
  assign ofs_ext  = {{10{q.instr[`MIE_OFS_MSB]}},
                     q.instr[`MIE_OFS_MSB:0]};              // [RULE5]

  // effective address: pre modes see the stepped pointer
  always_comb begin
    if (op == MIE_OP_LOAD_RELATIVE || op == MIE_OP_STORE_RELATIVE) begin
      eff_addr = 16'(ptr_now + ofs_ext);                    // [RULE5]
    end else if (is_pre) begin
      eff_addr = ptr_pre;                                   // [RULE3]
    end else begin
      eff_addr = ptr_now;                                   // [RULE3]
    end
  end

  // file registers sit in the bank picked by the bank select register
  assign file_addr = {4'h0, q.bank_select_reg,
                      q.instr[`MIE_FILE_MSB:0]};            // [RULE12]

  // the indirect register is only an alias: reads go to the store
  assign mem_raddr = (q.state == MIE_ST_EXEC) ? eff_addr
                                              : q.mem_addr; // [RULE2]

  // apb phases: one wait state (two while an instruction executes), then pready from a flop
  assign setup_seen = psel & penable & ~q.pready;
  assign bus_done   = psel & penable & q.pready;

  // address decode and read data selection
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `MIE_OFF_INSTR:    rd_mux = {16'h0000, q.instr};
      `MIE_OFF_WORK:     rd_mux = {24'h000000, q.work};
      `MIE_OFF_STATUS:   rd_mux = {29'h0, q.bad_op, q.carry, q.zero};
      `MIE_OFF_BANK:     rd_mux = {27'h0, q.bank_select_reg};
      `MIE_OFF_PCLATCH:  rd_mux = {25'h0, q.pc_high_latch};
      `MIE_OFF_PTR0:     rd_mux = {16'h0000, q.indirect_pointer[0]};
      `MIE_OFF_PTR1:     rd_mux = {16'h0000, q.indirect_pointer[1]};
      `MIE_OFF_MEM_ADDR: rd_mux = {16'h0000, q.mem_addr};
      `MIE_OFF_MEM_DATA: rd_mux = {24'h000000, mem_rdata};
      default:           mapped = 1'b0;
    endcase
  end

  // next state: bus side first, execution after so its sets win
  always_comb begin
    d           = q;
    mem_wr.we   = 1'b0;
    mem_wr.addr = q.mem_addr;
    mem_wr.data = pwdata[7:0];
    d.pready    = 1'b0;
    d.pslverr   = 1'b0;

    // hold off completion while an instruction is still running
    if (setup_seen && q.state == MIE_ST_IDLE) begin
      d.pready  = 1'b1;
      d.pslverr = ~mapped;
      d.prdata  = (pwrite || !mapped) ? 32'h0000_0000 : rd_mux;
    end

    // a write lands only at the completing edge, never on error
    if (bus_done && pwrite && !q.pslverr) begin
      case (paddr)
        `MIE_OFF_INSTR: begin
          d.instr = pwdata[15:0];
          d.state = MIE_ST_EXEC;
        end
        `MIE_OFF_WORK:     d.work = pwdata[7:0];
        `MIE_OFF_STATUS: begin
          d.zero   = pwdata[`MIE_ST_ZERO];
          d.carry  = pwdata[`MIE_ST_CARRY];
          d.bad_op = pwdata[`MIE_ST_BADOP];
        end
        `MIE_OFF_BANK:     d.bank_select_reg = pwdata[`MIE_BANK_MSB:0];
        `MIE_OFF_PCLATCH:  d.pc_high_latch = pwdata[`MIE_PCL_MSB:0];
        `MIE_OFF_PTR0:     d.indirect_pointer[0] = pwdata[15:0];
        `MIE_OFF_PTR1:     d.indirect_pointer[1] = pwdata[15:0];
        `MIE_OFF_MEM_ADDR: d.mem_addr = pwdata[15:0];
        `MIE_OFF_MEM_DATA: mem_wr.we = 1'b1;
        default: begin
        end
      endcase
    end

    // execution: one cycle, flags touched only where stated
    case (q.state)
      MIE_ST_IDLE: begin
      end
      MIE_ST_EXEC: begin
        d.state = MIE_ST_IDLE;
        case (op)
          MIE_OP_INDIRECT_LOAD: begin
            d.work = mem_rdata;                               // [RULE1]
            d.zero = (mem_rdata == 8'h00);                    // [RULE1]
            // pointer step never writes carry or zero
            d.indirect_pointer[sel] = ptr_post;               // [RULE6] [RULE8]
          end
          MIE_OP_INDIRECT_STORE: begin
            mem_wr.we   = 1'b1;                               // [RULE1]
            mem_wr.addr = eff_addr;                           // [RULE2]
            mem_wr.data = q.work;
            d.indirect_pointer[sel] = ptr_post;               // [RULE6] [RULE8]
          end
          MIE_OP_LOAD_RELATIVE: begin
            d.work = mem_rdata;                               // [RULE1]
            d.zero = (mem_rdata == 8'h00);                    // [RULE1]
          end
          MIE_OP_STORE_RELATIVE: begin
            mem_wr.we   = 1'b1;                               // [RULE5]
            mem_wr.addr = eff_addr;
            mem_wr.data = q.work;
          end
          MIE_OP_BANK_LITERAL: begin
            d.bank_select_reg = q.instr[`MIE_BANK_MSB:0];     // [RULE9]
          end
          MIE_OP_PC_LATCH_LIT: begin
            d.pc_high_latch = q.instr[`MIE_PCL_MSB:0];        // [RULE10]
          end
          MIE_OP_WORK_LITERAL: begin
            d.work = q.instr[`MIE_LIT_MSB:0];                 // [RULE11]
          end
          MIE_OP_WORK_TO_FILE: begin
            mem_wr.we   = 1'b1;                               // [RULE12]
            mem_wr.addr = file_addr;
            mem_wr.data = q.work;
          end
          default: begin
            // unknown opcode: sticky error, nothing else changes
            d.bad_op = 1'b1;
          end
        endcase
      end
      default: begin
        d.state = MIE_ST_IDLE;
      end
    endcase
  end

  // single register bank for the whole state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.state            <= MIE_ST_IDLE;
      q.instr            <= `MIE_RST_INSTR;
      q.work             <= `MIE_RST_WORK;
      q.zero             <= 1'b0;
      q.carry            <= 1'b0;
      q.bad_op           <= 1'b0;
      q.bank_select_reg  <= `MIE_RST_BANK;
      q.pc_high_latch    <= `MIE_RST_PCLATCH;
      q.indirect_pointer <= {`MIE_RST_PTR, `MIE_RST_PTR};
      q.mem_addr         <= `MIE_RST_PTR;
      q.prdata           <= `MIE_RST_DATA;
      q.pready           <= 1'b0;
      q.pslverr          <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;

endmodule : mie_move_exec

// ---- test/mie_move_exec_asserts.sv ----
// Purpose: port-level checks for the move executor
// Assumes: apb slave answering after one or two wait states
// Notes:   work is tracked only after a work literal op
`timescale 1ns/1ps
`include "mie_defines.svh"
module mie_move_exec_asserts
  import mie_pkg::*;
#(
  parameter int MEM_ADDR_W = 8
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       done;
  logic       mapped;
  logic       lit_ok_q;
  logic [7:0] lit_q;
  // completing transfer, and whether its address decodes
  assign done   = psel && penable && pready;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `MIE_OFF_MEM_DATA);
  // any other instruction or a work write may change work, so forget it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lit_ok_q <= 1'b0;
      lit_q    <= 8'h00;
    end else if (done && pwrite && paddr <= `MIE_OFF_WORK) begin
      lit_ok_q <= (paddr == `MIE_OFF_INSTR) && (pwdata[15:12] == 4'h5);
      lit_q    <= pwdata[7:0];
    end
  end
  sequence acc_start_s;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence rd_done_s(a);
    done && !pwrite && paddr == a;
  endsequence
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  wait_bound_a: assert property (acc_start_s |-> ##[1:2] pready)
    else $error("no answer within two wait states");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  bad_addr_err_a: assert property (done && !mapped |-> pslverr)
    else $error("unmapped address not refused");
  good_addr_ok_a: assert property (done && mapped |-> !pslverr)
    else $error("mapped address refused");
  narrow_bank_a: assert property (
    rd_done_s(`MIE_OFF_BANK) |-> prdata[31:5] == 27'h0)
    else $error("bank register upper bits set");
  narrow_latch_a: assert property (
    rd_done_s(`MIE_OFF_PCLATCH) |-> prdata[31:7] == 25'h0)
    else $error("pc latch upper bits set");
  work_lit_a: assert property (
    lit_ok_q && done && !pwrite && paddr == `MIE_OFF_WORK
    |-> prdata == {24'h0, lit_q})
    else $error("work differs from its literal");
endmodule : mie_move_exec_asserts

bind mie_move_exec mie_move_exec_asserts #(.MEM_ADDR_W(MEM_ADDR_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// ---- test/testbench.sv ----
// Purpose: directed apb tests of the move executor
// Assumes: store widened to 512 bytes so bank and file bits both show
// Notes:   every expectation comes from the instruction encoding
`timescale 1ns/1ps
`include "mie_defines.svh"
module testbench
  import mie_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] rd_q;
  logic        err_q;
  logic [11:0] pa;
  logic [11:0] po;
  logic [7:0]  ea;
  int          miscompares = 0;
  int          samples_checked = 0;

  always #10 pclk = ~pclk;

  mie_move_exec #(.MEM_ADDR_W(9)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // one apb transfer; an idle cycle after it keeps drivers single per step
  // pready is looked at on the falling edge, where it has settled, so the
  // edge that launches it is never mistaken for the completing one
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk(32'h0, 32'h1);
    // the answer stands unchanged up to the completing edge
    rd_q  = prdata;
    err_q = pslverr;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd_q, exp);
  endtask : rd

  task automatic ex(input logic [3:0] op, input logic s, input logic [7:0] lo);
    wr(`MIE_OFF_INSTR, {16'h0, op, 3'b000, s, lo});
  endtask : ex

  task automatic poke(input logic [15:0] a, input logic [7:0] d);
    wr(`MIE_OFF_MEM_ADDR, {16'h0, a});
    wr(`MIE_OFF_MEM_DATA, {24'h0, d});
  endtask : poke

  task automatic peek(input logic [15:0] a, input logic [7:0] exp);
    wr(`MIE_OFF_MEM_ADDR, {16'h0, a});
    rd(`MIE_OFF_MEM_DATA, {24'h0, exp});
  endtask : peek

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // the whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge pclk);
    // an expired limit counts as one mismatch
    chk(32'h0, 32'h1);
    wrap_up;
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values; store bytes are not reset so skipped
    for (int i = 0; i < 8; i++) rd(12'(4 * i), 32'h0);
    rd(12'h024, 32'h0);
    chk({31'h0, err_q}, 32'h1);
    wr(12'h006, 32'hff);
    chk({31'h0, err_q}, 32'h1);
    // literal ops must leave preset flags alone
    wr(`MIE_OFF_STATUS, 32'h3);
    ex(4'h5, 1'b0, 8'hff);
    ex(4'h3, 1'b0, 8'h0f);
    ex(4'h4, 1'b0, 8'h7f);
    rd(`MIE_OFF_WORK, 32'hff);
    rd(`MIE_OFF_BANK, 32'h0f);
    rd(`MIE_OFF_PCLATCH, 32'h7f);
    rd(`MIE_OFF_STATUS, 32'h3);
    // every mode on both pointers, bytes 0x0f..0x11 hold addr+0x40
    for (int a = 15; a < 18; a++) poke(16'(a), 8'(a + 64));
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 4; m++) begin
        pa = s[0] ? `MIE_OFF_PTR1 : `MIE_OFF_PTR0;
        po = s[0] ? `MIE_OFF_PTR0 : `MIE_OFF_PTR1;
        ea = (m == 0) ? 8'h11 : (m == 1) ? 8'h0f : 8'h10;
        wr(pa, 32'h10);
        wr(po, 32'h55);
        wr(`MIE_OFF_STATUS, 32'h3);
        ex(4'h1, s[0], 8'(m));
        rd(`MIE_OFF_WORK, {24'h0, ea + 8'h40});
        rd(`MIE_OFF_STATUS, 32'h2);
        rd(pa, m[0] ? 32'h0f : 32'h11);
        rd(po, 32'h55);
      end
    end
    // wrap at the top with a post-inc store, at zero with a pre-dec load
    ex(4'h5, 1'b0, 8'ha5);
    rd(`MIE_OFF_WORK, 32'ha5);
    wr(`MIE_OFF_PTR0, 32'hffff);
    ex(4'h2, 1'b0, 8'h02);
    rd(`MIE_OFF_PTR0, 32'h0);
    peek(16'hffff, 8'ha5);
    wr(`MIE_OFF_PTR1, 32'h0);
    ex(4'h1, 1'b1, 8'h01);
    rd(`MIE_OFF_WORK, 32'ha5);
    rd(`MIE_OFF_PTR1, 32'hffff);
    // both ends of the relative offset, pointer kept
    poke(16'h0020, 8'h00);
    wr(`MIE_OFF_PTR1, 32'h40);
    ex(4'h7, 1'b1, 8'h20);
    rd(`MIE_OFF_WORK, 32'h0);
    rd(`MIE_OFF_STATUS, 32'h3);
    ex(4'h5, 1'b0, 8'h3c);
    ex(4'h8, 1'b1, 8'h1f);
    peek(16'h005f, 8'h3c);
    rd(`MIE_OFF_PTR1, 32'h40);
    // direct store lands at bank*128+f
    ex(4'h3, 1'b0, 8'h02);
    ex(4'h6, 1'b0, 8'h7f);
    peek(16'h017f, 8'h3c);
    rd(`MIE_OFF_STATUS, 32'h3);
    ex(4'h9, 1'b0, 8'h00);
    rd(`MIE_OFF_STATUS, 32'h7);
    wrap_up;
  end
endmodule : testbench
